// >>> input_sync.sv
`timescale 1ns/1ns
`default_nettype none
module input_sync #(
    parameter int W = 5
) (
    // Clock, enable and reset
    input wire logic clk,
    input wire logic ce,
    input wire logic resetn,
    // Raw pins and filtered result
    input wire logic [W-1:0] pinIn,
    output logic [W-1:0] pinOut
);
    logic [W-1:0] s1_r; // First stage, read by s2_r only
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] out_r;

    // Three stages; a bit changes once stages two and three agree
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            out_r <= '0;
        end else if (ce) begin
            s1_r <= pinIn;
            s2_r <= s1_r;
            s3_r <= s2_r;
            out_r <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & out_r);
        end
    end

    assign pinOut = out_r;
endmodule : input_sync
`default_nettype wire

// >>> sgps_map.svh
`ifndef SGPS_MAP_SVH
`define SGPS_MAP_SVH

// Number of supervised switchgear units: switch and truck
`define SG_UNITS 2
// Width of every travel and dwell counter, in bits
`define TMR_W 24

// Register byte offsets on the APB side
`define OFS_CMD 8'h00
`define OFS_CFG 8'h04
`define OFS_OVR 8'h08
`define OFS_STAT 8'h0C
`define OFS_TON0 8'h10
`define OFS_TOFF0 8'h14
`define OFS_TDWELL0 8'h18
`define UNIT_STRIDE 8'h10

// Command register: close of unit u at bit 2u, open at bit 2u+1
`define CMD_CLOSE_BIT 0
`define CMD_OPEN_BIT 1
// Config register: wiring flags per unit and protection routing
`define CFG_WON_BIT 0
`define CFG_WOFF_BIT 2
`define CFG_PROT_BIT 4
`define CFG_W 5
`define CFG_RST 5'h0F
// Override register: enable at bit u, forced-closed value at bit 2+u
`define OVR_EN_BIT 0
`define OVR_VAL_BIT 2
`define OVR_W 4
// Status field of unit u sits at bits 8u+7..8u
`define STAT_W 8
`define STAT_FAULT_BIT 3
`define STAT_REJECT_BIT 7

// Reset values of the timers (travel 100000 cycles, 5 ms at 20 MHz; dwell 0)
`define TMOVE_RST 24'h0186A0
`define TDWELL_RST 24'h000000

`endif

// >>> sgps_pkg.sv
package sgps_pkg;

    // Supervision phase of one unit
    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_MOVE = 3'b010,
        PH_DWELL = 3'b100
    } phase_t;

    // Validated position code
    typedef enum logic [1:0] {
        POS_INDET = 2'h0,
        POS_OPEN = 2'h1,
        POS_CLOSED = 2'h2,
        POS_DISTURB = 2'h3
    } pos_t;

endpackage : sgps_pkg

// >>> switchgear_contact_model.sv
`timescale 1ns/1ns
`default_nettype none
module switchgear_contact_model #(
    parameter int DLY = 3
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Drive relays of both units
    input wire logic [1:0] closeDrive,
    input wire logic [1:0] openDrive,
    // Jams a unit in mid travel
    input wire logic [1:0] stuck,
    // Feedback contacts, both wired
    output logic [1:0] auxClosed,
    output logic [1:0] auxOpened
);
    // Travel progress of each unit, in cycles
    int cnt [2];

    // Leave the end position, travel DLY cycles, then report
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            auxClosed <= 2'h0;
            auxOpened <= 2'h3;
            cnt <= '{0, 0};
        end else begin
            for (int u = 0; u < 2; u++) begin
                if (!(closeDrive[u] | openDrive[u])) begin
                    cnt[u] <= 0; // Idle relays: contacts stay put
                end else if (cnt[u] < DLY) begin
                    // Both contacts open while moving
                    cnt[u] <= cnt[u] + 1;
                    auxClosed[u] <= 1'b0;
                    auxOpened[u] <= 1'b0;
                end else if (!stuck[u]) begin
                    auxClosed[u] <= closeDrive[u] & !openDrive[u];
                    auxOpened[u] <= openDrive[u];
                end
            end
        end
    end
endmodule : switchgear_contact_model
`default_nettype wire

// >>> switchgear_position_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
`include "sgps_map.svh"
// Summary of operation
// [R1] Sample both feedback contacts, derive position
// [R2] Two-bit code: indeterminate, open, closed, disturbed
// [R3] Close starts close timer, transit, closed flag
// [R4] Open starts open timer, transit, opened flag
// [R5] Timer expiry without new position sets fault
// [R6] Unequal contacts show closed or open directly
// [R7] Equal contacts: transit while timing, else disturbed
// [R8] Close drive ends at travel time or confirmation
// [R9] Open drive ends at travel time or confirmation
// [R10] Each unit has own travel and dwell times
// [R11] Pulled plug marks the unit withdrawn
// [R12] Withdrawn unit is forced to open
// [R13] Overrides refused while unit is withdrawn
// [R14] Switch and truck are two independent units
// [R15] User interlock blocks truck withdraw when closed; not done here, truck open is never blocked
// [R16] Installation wires at least one feedback contact
// [R17] Single contact still gives reduced supervision
// [R18] Protection commands may share the drive outputs
// [R19] Dwell after travel keeps transit, then final
// [R20] Counters loaded from settings, restart, reset clears
// [R21] Synchronised contacts; newest command supersedes
module switchgear_position_supervisor
    import sgps_pkg::*;
(
    // Clock, enable and reset
    input wire logic clk,
    input wire logic ce,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Contact and plug pins, unit 0 switch, unit 1 truck
    input wire logic [1:0] auxClosed,
    input wire logic [1:0] auxOpened,
    input wire logic plugOut,
    // Protection commands from logic on this clock
    input wire logic [1:0] protClose,
    input wire logic [1:0] protOpen,
    // Drive outputs and position codes
    output logic [1:0] closeDrive,
    output logic [1:0] openDrive,
    output logic [1:0] switchPos,
    output logic [1:0] truckPos
);

    ////////////////////////////////////////////////////////////////////
    // Declarations
    logic [4:0] syncOut; // Filtered pins
    logic [1:0] sOn; // Closed feedback per unit
    logic [1:0] sOff; // Opened feedback per unit
    logic sPlug; // Plug pulled, filtered
    logic [1:0] withdrawn; // Only the switch has a plug
    logic apbSetup;
    logic apbWrite;
    logic ovrWr;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] rdata_nxt;
    logic mapped_nxt;
    logic [`CFG_W-1:0] cfg_r;
    logic [`OVR_W-1:0] ovr_r;
    logic [`TMR_W-1:0] tOn_r [2];
    logic [`TMR_W-1:0] tOff_r [2];
    logic [`TMR_W-1:0] tDwell_r [2];
    logic [1:0] wOn; // Closed contact wired
    logic [1:0] wOff; // Opened contact wired
    logic [1:0] ovrEn;
    logic [1:0] cmdClose;
    logic [1:0] cmdOpen;
    logic [1:0] cmdAny;
    phase_t phase_r [2];
    pos_t pos_r [2];
    pos_t pos_nxt [2];
    logic [1:0] dirClose_r; // Direction of the running move
    logic [1:0] closeDrv_r;
    logic [1:0] openDrv_r;
    logic [1:0] fault_r; // Sticky travel fault
    logic [1:0] failed_r; // Last move failed, cleared by a command
    logic [1:0] reject_r; // Sticky refused override
    logic [1:0] reached;
    logic [1:0] wiredDir;
    logic [1:0] tmrLoad;
    logic [1:0] tmrStop;
    logic [1:0] tmrLast;
    logic [`TMR_W-1:0] tmrVal [2];
    logic [`STAT_W-1:0] stat [2];

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisation
    // Contacts and plug are asynchronous to clk
    input_sync #(.W(5)) u_sync ( // [R21]
        .clk(clk),
        .ce(ce),
        .resetn(resetn),
        .pinIn({plugOut, auxOpened, auxClosed}),
        .pinOut(syncOut)
    );
    assign sOn = syncOut[1:0]; // [R1]
    assign sOff = syncOut[3:2]; // [R1]
    assign sPlug = syncOut[4];
    // Truck has no control plug of its own
    assign withdrawn = {1'b0, sPlug}; // [R11] [R14]

    ////////////////////////////////////////////////////////////////////
    // APB slave
    assign apbSetup = psel && !penable && !pready_r;
    assign apbWrite = psel && penable && pready_r && pwrite;
    assign ovrWr = apbWrite && (paddr == `OFS_OVR);

    // Read mux, evaluated in the setup cycle
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        mapped_nxt = 1'b1;
        case (paddr)
            `OFS_CMD: rdata_nxt = 32'h0000_0000;
            `OFS_CFG: rdata_nxt = {27'h0, cfg_r};
            `OFS_OVR: rdata_nxt = {28'h0, ovr_r};
            `OFS_STAT: rdata_nxt = {16'h0, stat[1], stat[0]};
            default: mapped_nxt = 1'b0;
        endcase
        for (int u = 0; u < `SG_UNITS; u++) begin
            if (paddr == 8'(`OFS_TON0 + u * `UNIT_STRIDE)) begin
                rdata_nxt = {8'h00, tOn_r[u]};
                mapped_nxt = 1'b1;
            end
            if (paddr == 8'(`OFS_TOFF0 + u * `UNIT_STRIDE)) begin
                rdata_nxt = {8'h00, tOff_r[u]};
                mapped_nxt = 1'b1;
            end
            if (paddr == 8'(`OFS_TDWELL0 + u * `UNIT_STRIDE)) begin
                rdata_nxt = {8'h00, tDwell_r[u]};
                mapped_nxt = 1'b1;
            end
        end
    end

    // No wait state: answer is ready in the first access cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else if (ce) begin
            pready_r <= apbSetup;
            if (apbSetup) begin
                pslverr_r <= !mapped_nxt;
                prdata_r <= pwrite ? 32'h0000_0000 : rdata_nxt;
            end
        end
    end
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign prdata = prdata_r;

    ////////////////////////////////////////////////////////////////////
    // Configuration registers
    // Wiring and protection routing
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cfg_r <= `CFG_RST;
        end else if (ce && apbWrite && paddr == `OFS_CFG) begin
            cfg_r <= pwdata[`CFG_W-1:0]; // [R16]
        end
    end
    assign wOn = cfg_r[`CFG_WON_BIT +: 2];
    assign wOff = cfg_r[`CFG_WOFF_BIT +: 2];

    // Overrides; a withdrawn unit keeps its old override bits
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ovr_r <= '0;
        end else if (ce && ovrWr) begin
            for (int u = 0; u < `SG_UNITS; u++) begin
                if (!withdrawn[u]) begin // [R13]
                    ovr_r[`OVR_EN_BIT + u] <= pwdata[`OVR_EN_BIT + u];
                    ovr_r[`OVR_VAL_BIT + u] <= pwdata[`OVR_VAL_BIT + u];
                end
            end
        end
    end
    assign ovrEn = ovr_r[`OVR_EN_BIT +: 2];

    // Travel and dwell settings, separate per unit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int u = 0; u < `SG_UNITS; u++) begin
                tOn_r[u] <= `TMOVE_RST;
                tOff_r[u] <= `TMOVE_RST;
                tDwell_r[u] <= `TDWELL_RST;
            end
        end else if (ce && apbWrite) begin
            for (int u = 0; u < `SG_UNITS; u++) begin // [R10]
                if (paddr == 8'(`OFS_TON0 + u * `UNIT_STRIDE))
                    tOn_r[u] <= pwdata[`TMR_W-1:0];
                if (paddr == 8'(`OFS_TOFF0 + u * `UNIT_STRIDE))
                    tOff_r[u] <= pwdata[`TMR_W-1:0];
                if (paddr == 8'(`OFS_TDWELL0 + u * `UNIT_STRIDE))
                    tDwell_r[u] <= pwdata[`TMR_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Per-unit supervision
    for (genvar u = 0; u < `SG_UNITS; u++) begin : g_unit
        // Software pulse, or a routed protection command
        assign cmdClose[u] = (apbWrite && paddr == `OFS_CMD &&
            pwdata[2*u + `CMD_CLOSE_BIT]) ||
            (cfg_r[`CFG_PROT_BIT] && protClose[u]); // [R18]
        assign cmdOpen[u] = (apbWrite && paddr == `OFS_CMD &&
            pwdata[2*u + `CMD_OPEN_BIT]) ||
            (cfg_r[`CFG_PROT_BIT] && protOpen[u]); // [R18]
        assign cmdAny[u] = cmdClose[u] || cmdOpen[u];

        // Expected end position; an unwired side cannot confirm
        assign reached[u] = dirClose_r[u] ?
            (wOn[u] && sOn[u] && !(wOff[u] && sOff[u])) :
            (wOff[u] && sOff[u] && !(wOn[u] && sOn[u])); // [R17]
        assign wiredDir[u] = dirClose_r[u] ? wOn[u] : wOff[u];

        // Timer load: on a command, or dwell after confirmation
        always_comb begin
            tmrLoad[u] = cmdAny[u];
            tmrStop[u] = 1'b0;
            tmrVal[u] = cmdOpen[u] ? tOff_r[u] : tOn_r[u];
            if (!cmdAny[u] && phase_r[u] == PH_MOVE && reached[u]) begin
                tmrLoad[u] = (tDwell_r[u] != '0); // [R19]
                tmrStop[u] = (tDwell_r[u] == '0);
                tmrVal[u] = tDwell_r[u];
            end
        end

        travel_timer u_tmr ( // [R20]
            .clk(clk),
            .ce(ce),
            .resetn(resetn),
            .load(tmrLoad[u]),
            .stop(tmrStop[u]),
            .loadVal(tmrVal[u]),
            .busy(),
            .last(tmrLast[u])
        );

        // Phase and drives; open wins over a simultaneous close
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                phase_r[u] <= PH_IDLE; // [R20]
                dirClose_r[u] <= 1'b0;
                closeDrv_r[u] <= 1'b0;
                openDrv_r[u] <= 1'b0;
            end else if (ce) begin
                if (cmdOpen[u]) begin
                    phase_r[u] <= PH_MOVE; // [R4] [R21]
                    dirClose_r[u] <= 1'b0;
                    closeDrv_r[u] <= 1'b0;
                    openDrv_r[u] <= 1'b1;
                end else if (cmdClose[u]) begin
                    phase_r[u] <= PH_MOVE; // [R3] [R21]
                    dirClose_r[u] <= 1'b1;
                    closeDrv_r[u] <= 1'b1;
                    openDrv_r[u] <= 1'b0;
                end else begin
                    case (phase_r[u])
                        PH_MOVE: begin
                            if (reached[u] || tmrLast[u]) begin
                                closeDrv_r[u] <= 1'b0; // [R8]
                                openDrv_r[u] <= 1'b0; // [R9]
                            end
                            if (reached[u] && tDwell_r[u] != '0)
                                phase_r[u] <= PH_DWELL; // [R19]
                            else if (reached[u] || tmrLast[u])
                                phase_r[u] <= PH_IDLE;
                        end
                        PH_DWELL: begin
                            if (tmrLast[u])
                                phase_r[u] <= PH_IDLE;
                        end
                        default: phase_r[u] <= PH_IDLE;
                    endcase
                end
            end
        end

        // Sticky flags; a hardware set wins over a software clear
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                fault_r[u] <= 1'b0;
                failed_r[u] <= 1'b0;
                reject_r[u] <= 1'b0;
            end else if (ce) begin
                if (!cmdAny[u] && phase_r[u] == PH_MOVE && tmrLast[u] &&
                    !reached[u] && wiredDir[u]) begin
                    fault_r[u] <= 1'b1; // [R5]
                    failed_r[u] <= 1'b1; // [R17]
                end else begin
                    if (apbWrite && paddr == `OFS_STAT &&
                        pwdata[`STAT_W*u + `STAT_FAULT_BIT])
                        fault_r[u] <= 1'b0;
                    if (cmdAny[u])
                        failed_r[u] <= 1'b0;
                end
                if (ovrWr && withdrawn[u])
                    reject_r[u] <= 1'b1; // [R13]
                else if (apbWrite && paddr == `OFS_STAT &&
                    pwdata[`STAT_W*u + `STAT_REJECT_BIT])
                    reject_r[u] <= 1'b0;
            end
        end

        // Validated position
        always_comb begin
            if (withdrawn[u])
                pos_nxt[u] = POS_OPEN; // [R12]
            else if (ovrEn[u])
                pos_nxt[u] = ovr_r[`OVR_VAL_BIT + u] ? POS_CLOSED : POS_OPEN;
            else if (!wOn[u] && !wOff[u])
                pos_nxt[u] = POS_DISTURB;
            else if (phase_r[u] == PH_DWELL || (phase_r[u] == PH_MOVE &&
                reached[u] && tDwell_r[u] != '0))
                pos_nxt[u] = POS_INDET; // [R19]
            else if (wOn[u] && wOff[u] && sOn[u] != sOff[u])
                pos_nxt[u] = sOn[u] ? POS_CLOSED : POS_OPEN; // [R6]
            else if (phase_r[u] != PH_IDLE)
                pos_nxt[u] = POS_INDET; // [R7]
            else if (wOn[u] && wOff[u])
                pos_nxt[u] = POS_DISTURB; // [R7]
            else if (failed_r[u])
                pos_nxt[u] = POS_DISTURB; // [R17]
            else if (wOn[u])
                pos_nxt[u] = sOn[u] ? POS_CLOSED : POS_OPEN; // [R17]
            else
                pos_nxt[u] = sOff[u] ? POS_OPEN : POS_CLOSED; // [R17]
        end

        // Registered code keeps the outputs glitch free
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn)
                pos_r[u] <= POS_INDET;
            else if (ce)
                pos_r[u] <= pos_nxt[u]; // [R2]
        end

        // Status field of this unit
        assign stat[u] = {reject_r[u], withdrawn[u], openDrv_r[u],
            closeDrv_r[u], fault_r[u], phase_r[u] != PH_IDLE, pos_r[u]};
    end

    assign closeDrive = closeDrv_r;
    assign openDrive = openDrv_r;
    assign switchPos = pos_r[0];
    assign truckPos = pos_r[1];

    ////////////////////////////////////////////////////////////////////
    // Assertions on the switch unit
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);

    close_start_a: assert property ( // [R3]
        ce && cmdClose[0] && !cmdOpen[0] |=>
        phase_r[0] == PH_MOVE && closeDrv_r[0] && !openDrv_r[0])
        else $error("close command did not start a move");
    open_start_a: assert property ( // [R4]
        ce && cmdOpen[0] |=> phase_r[0] == PH_MOVE && openDrv_r[0] &&
        !closeDrv_r[0] && !dirClose_r[0])
        else $error("open command did not start a move");
    travel_fault_a: assert property ( // [R5]
        ce && !cmdAny[0] && phase_r[0] == PH_MOVE && tmrLast[0] &&
        !reached[0] && wiredDir[0] |=> fault_r[0] && phase_r[0] == PH_IDLE)
        else $error("expired travel did not raise fault");
    closed_code_a: assert property ( // [R6]
        ce && !withdrawn[0] && !ovrEn[0] && wOn[0] && wOff[0] &&
        phase_r[0] != PH_DWELL && sOn[0] && !sOff[0] &&
        !(phase_r[0] == PH_MOVE && reached[0] && tDwell_r[0] != '0) |=>
        pos_r[0] == POS_CLOSED)
        else $error("closed contacts not shown as closed");
    disturb_code_a: assert property ( // [R7]
        ce && !withdrawn[0] && !ovrEn[0] && wOn[0] && wOff[0] &&
        phase_r[0] == PH_IDLE && sOn[0] == sOff[0] |=>
        pos_r[0] == POS_DISTURB)
        else $error("equal contacts at rest not disturbed");
    close_release_a: assert property ( // [R8]
        ce && closeDrv_r[0] && !cmdAny[0] && (reached[0] || tmrLast[0])
        |=> !closeDrv_r[0])
        else $error("close drive held past end of travel");
    open_release_a: assert property ( // [R9]
        ce && openDrv_r[0] && !cmdAny[0] && (reached[0] || tmrLast[0])
        |=> !openDrv_r[0])
        else $error("open drive held past end of travel");
    plug_open_a: assert property ( // [R12]
        ce && withdrawn[0] |=> pos_r[0] == POS_OPEN)
        else $error("withdrawn switch not shown open");
    ovr_reject_a: assert property ( // [R13]
        ce && ovrWr && withdrawn[0] |=>
        reject_r[0] && $stable({ovr_r[`OVR_VAL_BIT], ovr_r[`OVR_EN_BIT]}))
        else $error("override accepted on withdrawn unit");

endmodule : switchgear_position_supervisor
`default_nettype wire

// >>> test_switchgear_position_supervisor.sv
`timescale 1ns/1ns
`default_nettype none
`include "sgps_map.svh"
module test_switchgear_position_supervisor import sgps_pkg::*;;
    // Bench drive and design outputs
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic plugOut = 0, pready, pslverr, re;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rq;
    logic [1:0] protClose = 0, protOpen = 0, stuck = 0, auxClosed, auxOpened;
    logic [1:0] closeDrive, openDrive, switchPos, truckPos;
    int num_errors = 0, checks = 0, seed = 32'had0f;

    always #25 clk = ~clk;

    switchgear_position_supervisor dut (.clk(clk), .ce(1'b1),
        .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .auxClosed(auxClosed), .auxOpened(auxOpened),
        .plugOut(plugOut), .protClose(protClose), .protOpen(protOpen),
        .closeDrive(closeDrive), .openDrive(openDrive),
        .switchPos(switchPos), .truckPos(truckPos));
    switchgear_contact_model gear (.clk(clk), .resetn(resetn),
        .closeDrive(closeDrive), .openDrive(openDrive), .stuck(stuck),
        .auxClosed(auxClosed), .auxOpened(auxOpened));

    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task check(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Verdict and end of run
    task summarize;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    // End position that a command aims at
    function pos_t target(input logic cls);
        return cls ? POS_CLOSED : POS_OPEN;
    endfunction : target

    // One APB transfer; one idle cycle after it keeps psel edges clean
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            summarize();
        end
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    // Counts high cycles of one drive; code sampled mid travel, once
    // the moving contacts have passed the pin filter
    task drive(input int u, input logic cls, output int n,
               output logic [1:0] mid);
        int k;
        n = 0;
        k = 0;
        while ((cls ? closeDrive[u] : openDrive[u]) !== 1'b1 && k < 10) begin
            @(posedge clk);
            k++;
        end
        while ((cls ? closeDrive[u] : openDrive[u]) === 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
            if (n == 7) mid = u ? truckPos : switchPos;
        end
        if (k == 10 || n == 300) begin
            num_errors++;
            summarize();
        end
    endtask : drive

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        int t, n;
        logic [1:0] m;
        repeat (2) @(posedge clk);
        check("reset outs", {closeDrive, openDrive, switchPos, truckPos}, 0);
        @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        check("idle pos", {switchPos, truckPos}, 4'h5);
        apb(0, `OFS_CFG, 0);
        check("cfg reset", rq, 32'h0F);
        apb(0, 8'hFC, 0);
        check("unmapped", rq, 0);
        check("bus error", re, 1);
        // Random travel times, every unit and direction
        for (int k = 0; k < 4; k++) begin
            t = 24 + ($random(seed) & 7);
            apb(1, 8'h10 + 8'({k[0], 4'h0}) + 8'({k[1], 2'h0}), t);
            apb(1, `OFS_CMD, 32'h1 << (2 * k[0] + k[1]));
            drive(k[0], !k[1], n, m);
            check("early release", n < t, 1);
            check("transit code", m, POS_INDET);
            repeat (4) @(posedge clk);
            check("end pos", k[0] ? truckPos : switchPos, target(!k[1]));
        end
        // Protection command routed to the same relay
        apb(1, `OFS_CFG, 32'h1F);
        protClose <= 2'h1;
        @(posedge clk);
        protClose <= 2'h0;
        drive(0, 1, n, m);
        repeat (4) @(posedge clk);
        check("prot close", switchPos, POS_CLOSED);
        // Truck close with a dwell: transit until the dwell has run
        apb(1, `OFS_TDWELL0 + `UNIT_STRIDE, 8);
        apb(1, `OFS_CMD, 32'h4);
        drive(1, 1, n, m);
        check("dwell transit", truckPos, POS_INDET);
        repeat (10) @(posedge clk);
        check("dwell end", truckPos, POS_CLOSED);
        // Truck with its closed contact only: open runs unsupervised
        apb(1, `OFS_CFG, 32'h17);
        apb(1, `OFS_CMD, 32'h8);
        drive(1, 0, n, m);
        check("single full", n, t);
        repeat (4) @(posedge clk);
        check("single pos", truckPos, POS_OPEN);
        // Jammed mechanism: full travel time, then fault
        stuck <= 2'h1;
        apb(1, `OFS_TOFF0, 5);
        apb(1, `OFS_CMD, 32'h2);
        drive(0, 0, n, m);
        check("full travel", n, 5);
        repeat (3) @(posedge clk);
        check("disturbed", switchPos, POS_DISTURB);
        apb(0, `OFS_STAT, 0);
        check("fault flag", rq[3], 1);
        // Plug pulled while switch not closed
        plugOut <= 1'b1;
        repeat (6) @(posedge clk);
        check("withdrawn pos", switchPos, POS_OPEN);
        apb(1, `OFS_OVR, 32'h5);
        apb(0, `OFS_STAT, 0);
        check("withdrawn bits", rq[7:6], 2'h3);
        apb(0, `OFS_OVR, 0);
        check("ovr kept", rq, 0);
        check("no override", {switchPos, truckPos}, 4'h5);
        summarize();
    end
endmodule : test_switchgear_position_supervisor
`default_nettype wire

// >>> travel_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "sgps_map.svh"
module travel_timer (
    // Clock, enable and reset
    input wire logic clk,
    input wire logic ce,
    input wire logic resetn,
    // Control
    input wire logic load,
    input wire logic stop,
    input wire logic [`TMR_W-1:0] loadVal,
    // Status
    output logic busy,
    output logic last
);
    logic [`TMR_W-1:0] cnt_r; // Cycles left
    logic busy_r;

    // Down counter; a zero setting still runs one cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
        end else if (ce) begin
            if (load) begin
                cnt_r <= (loadVal == '0) ? `TMR_W'(1) : loadVal;
                busy_r <= 1'b1;
            end else if (stop || last) begin
                busy_r <= 1'b0;
            end else if (busy_r) begin
                cnt_r <= cnt_r - `TMR_W'(1);
            end
        end
    end

    assign busy = busy_r;
    assign last = busy_r && (cnt_r == `TMR_W'(1));
endmodule : travel_timer
`default_nettype wire
